// ### hdl/dspl_port.sv
/*
  Dual-mode serial port front end: 4-wire shifter on the serial clock,
  target address capture, alert driver and round robin channel stepper.
  Assumes srst_i is the power-up reset and that the core keeps tx_data
  stable around each byte start of a 4-wire frame.
*/
`timescale 1ns/1ps
module dspl_port (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic sclk_i,
  input wire logic sda_i,
  input wire logic cs_n_i,
  input wire logic add_high_i,
  input wire logic add_float_i,
  input wire logic spi_select_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_load_i,
  input wire logic limit_i,
  input wire logic alert_high_i,
  input wire logic rr_en_i,
  input wire logic ext_sel_i,
  input wire logic conv_done_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic [6:0] i2c_addr_o,
  output logic addr_locked_o,
  output logic spi_mode_o,
  output logic alert_o,
  output logic alert_oe_o,
  output logic [3:0] chan_o
);
  // ------------------------------------------------------------
  // Pin synchronisers (core domain)
  // ------------------------------------------------------------
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [1:0] s3_q;
  always_ff @(posedge clk_i) begin
    s1_q <= {add_float_i, add_high_i, sda_i, sclk_i};
    s2_q <= s1_q;
    s3_q <= s2_q[1:0];
  end
  wire scl_rise = s2_q[0] & ~s3_q[0];
  wire bus_start = s2_q[0] & s3_q[0] & ~s2_q[1] & s3_q[1];
  wire bus_stop = s2_q[0] & s3_q[0] & s2_q[1] & ~s3_q[1];

  // ------------------------------------------------------------
  // Address capture
  // ------------------------------------------------------------
  dspl_pkg::dspl_i2c_e st_q, st_d;
  logic [3:0] ecnt_q, ecnt_d;
  logic [6:0] sh_q, sh_d;
  logic [1:0] vcnt_q, vcnt_d;
  logic [6:0] addr_q, addr_d;
  logic lock_q, lock_d;
  logic spi_q, spi_d;
  logic [6:0] cand;

  always_comb begin
    cand = s2_q[3] ? dspl_pkg::ADDR_FLOAT :
           (s2_q[2] ? dspl_pkg::ADDR_HIGH : dspl_pkg::ADDR_LOW); // [R1]
    st_d = st_q;
    ecnt_d = ecnt_q;
    sh_d = sh_q;
    vcnt_d = vcnt_q;
    addr_d = addr_q;
    lock_d = lock_q;
    spi_d = spi_q | spi_select_i; // [R10]
    if (bus_start && !spi_q) begin
      st_d = dspl_pkg::I2C_ADDR;
      ecnt_d = 4'h0;
    end else if (bus_stop) begin
      st_d = dspl_pkg::I2C_IDLE;
    end else begin
      case (st_q)
        dspl_pkg::I2C_IDLE: st_d = dspl_pkg::I2C_IDLE;
        dspl_pkg::I2C_ADDR: begin
          if (scl_rise) begin
            ecnt_d = ecnt_q + 4'h1;
            if (ecnt_q < dspl_pkg::ADDR_BITS) begin
              sh_d = {sh_q[5:0], s2_q[1]};
            end
            if (ecnt_d == dspl_pkg::SCL_LATCH_EDGE) begin // [R2]
              st_d = dspl_pkg::I2C_DONE;
              if (sh_q == cand && vcnt_q != dspl_pkg::VALID_MAX) begin
                vcnt_d = vcnt_q + 2'h1;
                if (vcnt_d == dspl_pkg::VALID_MAX && !lock_q) begin // [R3]
                  addr_d = cand;
                  lock_d = 1'b1;
                end
              end
            end
          end
        end
        dspl_pkg::I2C_DONE: st_d = dspl_pkg::I2C_DONE;
        default: st_d = dspl_pkg::I2C_IDLE;
      endcase
    end
  end

  // Count only clears at power-up so capture happens once
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_q <= dspl_pkg::I2C_IDLE;
      ecnt_q <= 4'h0;
      sh_q <= 7'h00;
      vcnt_q <= 2'h0; // [R11]
      addr_q <= dspl_pkg::ADDR_RST;
      lock_q <= 1'b0;
      spi_q <= 1'b0; // [R10]
    end else begin
      st_q <= st_d;
      ecnt_q <= ecnt_d;
      sh_q <= sh_d;
      vcnt_q <= vcnt_d;
      addr_q <= addr_d;
      lock_q <= lock_d;
      spi_q <= spi_d;
    end
  end

  // ------------------------------------------------------------
  // 4-wire shifter (serial clock domain)
  // ------------------------------------------------------------
  // Frame end clears the shifter; the clock may stop between frames
  logic lm1_q;
  logic lm2_q;
  logic [2:0] bcnt_q;
  logic [7:0] rsh_q;
  logic [7:0] rbyte_q = 8'h00;
  logic rtgl_q = 1'b0;
  logic [2:0] ocnt_q;
  logic [7:0] osh_q;
  logic doe_q;
  logic [7:0] tx_q;
  always_ff @(posedge sclk_i) begin
    lm1_q <= spi_q;
    lm2_q <= lm1_q;
  end
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin // [R9]
      bcnt_q <= 3'h0;
      rsh_q <= 8'h00;
    end else begin
      bcnt_q <= bcnt_q + 3'h1;
      rsh_q <= {rsh_q[6:0], sda_i}; // [R5]
    end
  end
  always_ff @(posedge sclk_i) begin
    if (!cs_n_i && lm2_q && bcnt_q == dspl_pkg::BYTE_LAST) begin
      rbyte_q <= {rsh_q[6:0], sda_i};
      rtgl_q <= ~rtgl_q;
    end
  end
  // Word crossing is quasi-static: sampled only at a byte start
  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      ocnt_q <= 3'h0;
      osh_q <= 8'h00;
      doe_q <= 1'b0;
    end else begin
      ocnt_q <= ocnt_q + 3'h1;
      if (ocnt_q == 3'h0) begin
        osh_q <= {tx_q[6:0], 1'b0};
        doe_q <= lm2_q & ~tx_q[7]; // [R4]
      end else begin
        osh_q <= {osh_q[6:0], 1'b0};
        doe_q <= lm2_q & ~osh_q[7]; // [R4]
      end
    end
  end
  assign dout_oe_o = doe_q;
  always_ff @(posedge sclk_i) begin
    dout_o <= 1'b0;
  end

  // ------------------------------------------------------------
  // Core side of the 4-wire data path
  // ------------------------------------------------------------
  logic [7:0] tx_d;
  logic t1_q;
  logic t2_q;
  logic t3_q;
  logic [7:0] rx_q, rx_d;
  logic rxv_q, rxv_d;
  always_comb begin
    tx_d = tx_load_i ? tx_data_i : tx_q;
    rxv_d = t2_q ^ t3_q;
    rx_d = rxv_d ? rbyte_q : rx_q;
  end
  always_ff @(posedge clk_i) begin
    t1_q <= rtgl_q;
    t2_q <= t1_q;
    if (srst_i) begin
      t3_q <= t2_q;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      rxv_q <= 1'b0;
    end else begin
      t3_q <= t2_q;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rxv_q <= rxv_d;
    end
  end

  // ------------------------------------------------------------
  // Alert and round robin
  // ------------------------------------------------------------
  logic aoe_q, aoe_d;
  logic [3:0] ch_q, ch_d;
  logic [3:0] ch_n;
  always_comb begin
    // Open drain: active high asserts by releasing the pin
    aoe_d = alert_high_i ? ~limit_i : limit_i; // [R7]
    ch_n = ch_q + 4'h1;
    if (ch_q == dspl_pkg::CH_LAST) begin
      ch_n = dspl_pkg::CH_VDD;
    end else if (ext_sel_i && ch_n == dspl_pkg::CH_AIN1) begin
      ch_n = dspl_pkg::CH_AIN3;
    end else if (!ext_sel_i && ch_n == dspl_pkg::CH_TEXT) begin
      ch_n = dspl_pkg::CH_AIN1;
    end
    ch_d = !rr_en_i ? dspl_pkg::CH_VDD : (conv_done_i ? ch_n : ch_q); // [R8]
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      aoe_q <= 1'b0;
      ch_q <= dspl_pkg::CH_VDD;
      alert_o <= 1'b0;
    end else begin
      aoe_q <= aoe_d;
      ch_q <= ch_d;
      alert_o <= 1'b0;
    end
  end

  assign rx_byte_o = rx_q;
  assign rx_valid_o = rxv_q;
  assign i2c_addr_o = addr_q;
  assign addr_locked_o = lock_q;
  assign spi_mode_o = spi_q;
  assign alert_oe_o = aoe_q;
  assign chan_o = ch_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  addr_from_pin_a: assert property ($rose(lock_q) |-> addr_q == $past(cand)) // [R1]
    else $error("latched address differs from select level");
  second_valid_a: assert property ($rose(lock_q) |-> $past(vcnt_q) == 2'h1) // [R2]
    else $error("address latched before second valid transaction");
  addr_frozen_a: assert property (lock_q |=> lock_q && $stable(addr_q)) // [R3]
    else $error("latched address changed");
  count_sticky_a: assert property (vcnt_q >= $past(vcnt_q)) // [R11]
    else $error("valid count went down without power-up");
  spi_locked_a: assert property (spi_q |=> spi_q) // [R10]
    else $error("4-wire mode left without power-up");
  alert_low_a: assert property (limit_i && !alert_high_i |=> aoe_q) // [R7]
    else $error("active low alert not driven");
  rr_wrap_a: assert property (rr_en_i && conv_done_i && ch_q == dspl_pkg::CH_LAST // [R8]
    |=> ch_q == dspl_pkg::CH_VDD)
    else $error("round robin did not wrap to first channel");
  rr_hold_a: assert property (rr_en_i && !conv_done_i |=> $stable(ch_q)) // [R8]
    else $error("channel moved without a finished measurement");
  byte_done_a: assert property (@(posedge sclk_i) disable iff (cs_n_i) // [R5]
    lm2_q && bcnt_q == 3'h7 |=> rtgl_q != $past(rtgl_q) && rbyte_q[0] == $past(sda_i))
    else $error("byte not handed over on the eighth rising clock");
  dout_mode_a: assert property (@(negedge sclk_i) disable iff (cs_n_i) // [R4]
    !lm2_q |=> !doe_q)
    else $error("data output driven outside 4-wire mode");
endmodule

// ### inc/dspl_pkg.sv
/*
  Constants shared by the dual-mode serial port front end.
  Assumes a 100 MHz core clock and a serial clock supplied by the host.
*/
// What this block does
// R1 - Address from three-level select: low, float, high
// R2 - Latch select on 8th clock, second valid
// R3 - After latch, select pin changes are ignored
// R4 - 4-wire read data changes on falling edge
// R5 - 4-wire input bits sampled on rising edge
// R6 - Host supplies the only serial clock
// R7 - Alert on limit; polarity selectable, default low
// R8 - Round robin steps channels in order, skipping slot 2 (ext_sel_i low) or slots 3-4 (ext_sel_i high)
// R9 - Chip select low frames each 4-wire transfer
// R10 - Starts in I2C; 4-wire locks until power-up
// R11 - Valid transaction count cleared only at power-up
package dspl_pkg;
  // ------------------------------------------------------------
  // Target addresses
  // ------------------------------------------------------------
  localparam logic [6:0] ADDR_LOW = 7'h48;
  localparam logic [6:0] ADDR_FLOAT = 7'h4a;
  localparam logic [6:0] ADDR_HIGH = 7'h4b;
  localparam logic [6:0] ADDR_RST = 7'h00;
  // ------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------
  localparam logic [3:0] SCL_LATCH_EDGE = 4'h8;
  localparam logic [3:0] ADDR_BITS = 4'h7;
  localparam logic [1:0] VALID_MAX = 2'h2;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // ------------------------------------------------------------
  // Round robin channel slots
  // ------------------------------------------------------------
  localparam logic [3:0] CH_VDD = 4'h0;
  localparam logic [3:0] CH_TEXT = 4'h2;
  localparam logic [3:0] CH_AIN1 = 4'h3;
  localparam logic [3:0] CH_AIN3 = 4'h5;
  localparam logic [3:0] CH_LAST = 4'ha;
  typedef enum logic [1:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_DONE
  } dspl_i2c_e;
endpackage

// ### sim/dspl_host.sv
/*
  Host serial controller model: I2C address phases and 4-wire frames.
  Assumes the bench calls its tasks one at a time; clock stands high between frames.
*/
`timescale 1ns/1ps
module dspl_host (
  input wire logic dout_oe_i,
  output logic sclk_o,
  output logic sda_o,
  output logic cs_n_o
);
  logic [7:0] bits;
  // ----------------------------------------
  // Idle: pulled-up lines, clock still
  // ----------------------------------------
  initial begin
    sclk_o = 1'b1;
    sda_o = 1'b1;
    cs_n_o = 1'b1;
  end
  // Slow halves so the synced sampler sees every level
  task automatic i2c_addr(input logic [6:0] a);
    bits = {a, 1'b0};
    sda_o = 1'b0;
    #60;
    for (int i = 7; i >= 0; i--) begin
      sclk_o = 1'b0;
      sda_o = bits[i];
      #60;
      sclk_o = 1'b1;
      #60;
    end
    sclk_o = 1'b0;
    sda_o = 1'b0;
    #60;
    sclk_o = 1'b1;
    #60;
    sda_o = 1'b1;
    #60;
  endtask
  // 30 ns link clock, idle high; data set on the fall, read back before the rise
  task automatic spi_frame(input logic [15:0] tx, output logic [15:0] rd);
    #7;
    cs_n_o = 1'b0;
    #30;
    for (int i = 15; i >= 0; i--) begin
      sclk_o = 1'b0;
      sda_o = tx[i];
      #15;
      rd[i] = ~dout_oe_i;
      sclk_o = 1'b1;
      #15;
    end
    #30;
    cs_n_o = 1'b1;
    sda_o = 1'b1;
  endtask
endmodule

// ### sim/testbench.sv
/*
  Bench for the serial port front end: round robin, alert, address capture, 4-wire.
  Assumes dspl_host drives the serial pins and srst_i stands for power-up.
*/
`timescale 1ns/1ps
module testbench;
  logic clk, srst, sclk, sda, cs_n, add_high, add_float, spi_select, tx_load, limit;
  logic alert_high, rr_en, ext_sel, conv_done, dout, dout_oe, rx_valid, locked;
  logic spi_mode, alert, alert_oe;
  logic [7:0] tx_data, rx_byte;
  logic [6:0] i2c_addr;
  logic [3:0] chan;
  int err_total, checks_done, rxv_cnt;
  always #5 clk = ~clk;
  // Byte pulses last one core cycle, so the falling edge sees each once
  always @(negedge clk) begin
    if (rx_valid === 1'b1) rxv_cnt++;
  end
  dspl_port dspl_port_inst (.clk_i(clk), .srst_i(srst), .sclk_i(sclk), .sda_i(sda),
    .cs_n_i(cs_n), .add_high_i(add_high), .add_float_i(add_float),
    .spi_select_i(spi_select), .tx_data_i(tx_data), .tx_load_i(tx_load), .limit_i(limit),
    .alert_high_i(alert_high), .rr_en_i(rr_en), .ext_sel_i(ext_sel),
    .conv_done_i(conv_done), .dout_o(dout), .dout_oe_o(dout_oe), .rx_byte_o(rx_byte),
    .rx_valid_o(rx_valid), .i2c_addr_o(i2c_addr), .addr_locked_o(locked),
    .spi_mode_o(spi_mode), .alert_o(alert), .alert_oe_o(alert_oe), .chan_o(chan));
  dspl_host dspl_host_inst (.dout_oe_i(dout_oe), .sclk_o(sclk), .sda_o(sda), .cs_n_o(cs_n));
  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk) srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic step_chan(input logic [3:0] exp);
    @(posedge clk) conv_done <= 1'b1;
    @(posedge clk) conv_done <= 1'b0;
    @(negedge clk) check({4'h0, chan}, {4'h0, exp});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic rr_test();
    logic [3:0] e;
    e = 4'h0;
    step_chan(e);
    @(posedge clk) rr_en <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk) ext_sel <= m[0];
      for (int k = 0; k < 10; k++) begin
        e = (e == 4'ha) ? 4'h0 : e + 4'h1;
        if (m == 0 && e == 4'h2) e = 4'h3;
        if (m == 1 && e == 4'h3) e = 4'h5;
        step_chan(e);
      end
    end
  endtask
  task automatic alert_test(input logic lim, input logic hi, input logic exp);
    @(posedge clk) limit <= lim;
    alert_high <= hi;
    repeat (2) @(posedge clk);
    @(negedge clk) check({7'h0, alert_oe}, {7'h0, exp});
    check({7'h0, alert}, 8'h00);
  endtask
  // A foreign address first: it must not count toward the two
  task automatic i2c_lock(input logic f, input logic h, input logic [6:0] a);
    int n;
    @(posedge clk) add_float <= f;
    add_high <= h;
    dspl_host_inst.i2c_addr(a ^ 7'h01);
    dspl_host_inst.i2c_addr(a);
    repeat (8) @(posedge clk);
    check({7'h0, locked}, 8'h00);
    dspl_host_inst.i2c_addr(a);
    n = 0;
    while (locked !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (locked !== 1'b1) err_total++;
    check({1'b0, i2c_addr}, {1'b0, a});
  endtask
  // Select pin moves after capture: address must stay put
  task automatic i2c_frozen();
    @(posedge clk) add_float <= 1'b0;
    add_high <= 1'b1;
    dspl_host_inst.i2c_addr(7'h4b);
    dspl_host_inst.i2c_addr(7'h4b);
    repeat (8) @(posedge clk);
    check({1'b0, i2c_addr}, 8'h4a);
    check({7'h0, locked}, 8'h01);
  endtask
  task automatic spi_test();
    logic [15:0] rd;
    @(posedge clk) spi_select <= 1'b1;
    tx_data <= 8'ha5;
    tx_load <= 1'b1;
    @(posedge clk) spi_select <= 1'b0;
    tx_load <= 1'b0;
    @(negedge clk) check({7'h0, spi_mode}, 8'h01);
    dspl_host_inst.spi_frame(16'hc33c, rd);
    repeat (8) @(posedge clk);
    check(rx_byte, 8'h3c);
    check(rxv_cnt[7:0], 8'h02);
    check(rd[7:0], 8'ha5);
    check({7'h0, dout}, 8'h00);
    check({7'h0, dout_oe}, 8'h00);
    check({7'h0, spi_mode}, 8'h01);
  endtask
  initial begin
    {clk, srst, add_high, add_float, spi_select, tx_load, limit} = 7'h20;
    {alert_high, rr_en, ext_sel, conv_done, tx_data} = 12'h000;
    err_total = 0;
    checks_done = 0;
    do_reset();
    rr_test();
    alert_test(1'b1, 1'b0, 1'b1);
    alert_test(1'b1, 1'b1, 1'b0);
    alert_test(1'b0, 1'b0, 1'b0);
    i2c_lock(1'b1, 1'b0, 7'h4a);
    i2c_frozen();
    do_reset();
    i2c_lock(1'b0, 1'b1, 7'h4b);
    do_reset();
    i2c_lock(1'b0, 1'b0, 7'h48);
    spi_test();
    print_verdict();
  end
endmodule
